//--- trc_consts.vh
`ifndef TRC_CONSTS_VH
`define TRC_CONSTS_VH
// register addresses
`define TRC_ADDR_LOCAL 8'h00
`define TRC_ADDR_REM_INT 8'h01
`define TRC_ADDR_CFG_RD 8'h03
`define TRC_ADDR_CFG_WR 8'h09
`define TRC_ADDR_REM_FRAC 8'h10
// reset values
`define TRC_RESULT_RST 8'h00
`define TRC_CFG_RST 8'h00
`define TRC_PTR_RST 8'h00
// configuration field positions
`define TRC_CFG_MASK_BIT 7
`define TRC_CFG_STBY_BIT 6
`define TRC_CFG_PINSEL_BIT 5
`define TRC_CFG_RANGE_BIT 2
// writable configuration bits (reserved bits held at zero)
`define TRC_CFG_WMASK 8'he4
// format constants (whole degrees)
`define TRC_OFFSET_DEG 10'h040
`define TRC_MAX_STRAIGHT 10'h07f
`define TRC_MAX_OFFSET 10'h0ff
`endif

//--- trc_fmt.v
`timescale 1ns/1ps
`default_nettype none
`include "trc_consts.vh"
// ========================================
// temperature encoder
module trc_fmt (
  // raw temperature, signed whole degrees
  input wire signed [9:0] temp_i,
  // 1 = offset binary range
  input wire ext_i,
  // encoded byte
  output reg [7:0] code_o
);
  reg signed [10:0] adj;
  always @* begin
    adj = {temp_i[9], temp_i};
    if (ext_i) begin
      adj = {temp_i[9], temp_i} + {1'b0, `TRC_OFFSET_DEG};
      if (adj[10])
        code_o = 8'h00;
      else if (adj > $signed({1'b0, `TRC_MAX_OFFSET}))
        code_o = 8'hff;
      else
        code_o = adj[7:0];
    end else begin
      if (adj[10])
        code_o = 8'h00;
      else if (adj > $signed({1'b0, `TRC_MAX_STRAIGHT}))
        code_o = 8'h7f;
      else
        code_o = adj[7:0];
    end
  end
endmodule
`default_nettype wire

//--- trc_sync.v
`timescale 1ns/1ps
`default_nettype none
// ========================================
// two-flop synchroniser
module trc_sync (
  // clock and reset
  input wire mclk_i,
  input wire rstn_i,
  // asynchronous level in, synchronised out
  input wire d_i,
  output reg q_o
);
  reg meta;
  always @(posedge mclk_i) begin
    if (!rstn_i) begin
      meta <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule
`default_nettype wire

//--- trc_regs.v
// Contract
// - local result byte at address 0x00
// - remote result integer 0x01, fraction 0x10
// - fraction bits 7:6 only, rest zero
// - fraction read freezes integer byte
// - config bit 2 selects range, both channels
// - new format from next conversion on
// - offset binary adds 64 degrees
// - straight binary clamps to 0..127
// - range change leaves limits untouched
// - first write byte loads pointer
// - later bytes and reads use pointer
// - pointer resets to 0x00
// - results converter-written, read-only, reset 0x00
// - config read 0x03, write 0x09, reset 0x00
// - mask bit gates interrupt, ignored otherwise
// - standby stops conversions, bus stays alive
// - alarms stay live in standby
// - config bit 5 selects alarm pin function
// - shorted sensor keeps last good remote
`timescale 1ns/1ps
`default_nettype none
`include "trc_consts.vh"
module trc_regs (
  // clock and reset
  input wire mclk_i,
  input wire rstn_i,
  // bus transaction side (same clock)
  input wire wr_first_i,
  input wire wr_data_i,
  input wire rd_i,
  input wire [7:0] wdata_i,
  // converter side (same clock)
  input wire conv_done_i,
  input wire conv_remote_i,
  input wire signed [9:0] conv_int_i,
  input wire [1:0] conv_frac_i,
  // remote sensor short indication from analog pin
  input wire remote_short_i,
  // alarm sources from comparison logic
  input wire alert_req_i,
  input wire high_trip_i,
  input wire overtemp_output_primary_trip_i,
  // read data and status
  output reg [7:0] rdata_o,
  output reg conv_run_o,
  output reg [7:0] cfg_o,
  // alarm pins, open drain: output low level with enable
  output reg overtemp_output_primary_out_o,
  output reg overtemp_output_primary_oe_n_o,
  output reg pin6_out_o,
  output reg pin6_oe_n_o
);
  // ========================================
  // state
  reg [7:0] local_temp_value;
  reg [7:0] remote_temp_integer;
  reg [7:0] remote_temp_fraction;
  reg [7:0] register_pointer;
  reg int_frozen;
  wire short_s;
  wire [7:0] code;
  wire ext = cfg_o[`TRC_CFG_RANGE_BIT];
  wire stby = cfg_o[`TRC_CFG_STBY_BIT];
  wire pin_sel = cfg_o[`TRC_CFG_PINSEL_BIT];
  wire interrupt_mask_bit = cfg_o[`TRC_CFG_MASK_BIT];
  wire rd_frac = rd_i && (register_pointer == `TRC_ADDR_REM_FRAC);
  wire rd_int = rd_i && (register_pointer == `TRC_ADDR_REM_INT);
  wire take = conv_done_i && !stby;
  wire take_rem = take && conv_remote_i && !short_s;
  reg overtemp_output_secondary;
  reg alarm6;
  reg [7:0] next_rdata;

  trc_sync u_sync (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .d_i(remote_short_i),
    .q_o(short_s)
  );

  // range sampled per conversion, so a change applies from the next one
  trc_fmt u_fmt (
    .temp_i(conv_int_i),
    .ext_i(ext),
    .code_o(code)
  );

  // ========================================
  // pointer and configuration
  always @(posedge mclk_i) begin
    if (!rstn_i) begin
      register_pointer <= `TRC_PTR_RST;
      cfg_o <= `TRC_CFG_RST;
    end else if (wr_first_i) begin
      register_pointer <= wdata_i;
    end else if (wr_data_i && register_pointer == `TRC_ADDR_CFG_WR) begin
      cfg_o <= wdata_i & `TRC_CFG_WMASK;
    end
  end

  // ========================================
  // result registers, converter only; limits are not touched here
  always @(posedge mclk_i) begin
    if (!rstn_i) begin
      local_temp_value <= `TRC_RESULT_RST;
      remote_temp_integer <= `TRC_RESULT_RST;
      remote_temp_fraction <= `TRC_RESULT_RST;
      int_frozen <= 1'b0;
    end else begin
      if (take && !conv_remote_i)
        local_temp_value <= code;
      if (take_rem) begin
        remote_temp_fraction <= {conv_frac_i, 6'h00};
        if (!int_frozen && !rd_frac)
          remote_temp_integer <= code;
      end
      if (rd_frac)
        int_frozen <= 1'b1;
      else if (rd_int)
        int_frozen <= 1'b0;
    end
  end

  // ========================================
  // read mux
  always @* begin
    case (register_pointer)
      `TRC_ADDR_LOCAL: next_rdata = local_temp_value;
      `TRC_ADDR_REM_INT: next_rdata = remote_temp_integer;
      `TRC_ADDR_CFG_RD: next_rdata = cfg_o;
      `TRC_ADDR_REM_FRAC: next_rdata = remote_temp_fraction;
      default: next_rdata = 8'h00;
    endcase
  end

  // ========================================
  // alarm pins, evaluated also in standby
  always @* begin
    overtemp_output_secondary = high_trip_i;
    if (pin_sel)
      alarm6 = overtemp_output_secondary;
    else
      alarm6 = alert_req_i && !interrupt_mask_bit;
  end

  always @(posedge mclk_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
      conv_run_o <= 1'b0;
      overtemp_output_primary_out_o <= 1'b0;
      overtemp_output_primary_oe_n_o <= 1'b1;
      pin6_out_o <= 1'b0;
      pin6_oe_n_o <= 1'b1;
    end else begin
      rdata_o <= next_rdata;
      conv_run_o <= !stby;
      overtemp_output_primary_oe_n_o <= !overtemp_output_primary_trip_i;
      pin6_oe_n_o <= !alarm6;
    end
  end
endmodule
`default_nettype wire

//--- trc_host.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// host model: turns bench requests into bus strobes
module trc_host (
  // request: 1 pointer, 2 data, 3 read
  input wire logic mclk_i,
  input wire logic [1:0] op_i,
  input wire logic [7:0] byte_i,
  // strobes to block
  output logic wr_first_o,
  output logic wr_data_o,
  output logic rd_o,
  output logic [7:0] wdata_o
);
  always @(posedge mclk_i) begin
    wr_first_o <= op_i == 2'd1;
    wr_data_o <= op_i == 2'd2;
    rd_o <= op_i == 2'd3;
    wdata_o <= op_i == 2'd0 ? ~byte_i : op_i == 2'd2 ? byte_i & 8'he4 : byte_i;
  end
endmodule
`default_nettype wire

//--- trc_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// checker
module trc_regs_chk (
  // clock, reset, bus, alarm trips
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic wr_first_i,
  input wire logic wr_data_i,
  input wire logic [7:0] wdata_i,
  input wire logic high_trip_i,
  input wire logic overtemp_output_primary_trip_i,
  // outputs
  input wire logic [7:0] rdata_o,
  input wire logic [7:0] cfg_o,
  input wire logic conv_run_o,
  input wire logic overtemp_output_primary_oe_n_o,
  input wire logic pin6_oe_n_o
);
  logic [7:0] ptr;
  logic [7:0] wv;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  always @(posedge mclk_i) begin
    if (!rstn_i) begin
      ptr <= 8'h00;
    end else if (wr_first_i) begin
      ptr <= wdata_i;
    end
    if (wr_data_i) begin
      wv <= wdata_i;
    end
  end
  a_cfg_rsvd_zero: assert property ((cfg_o & 8'h1b) == 8'h00) else $error("rsvd");
  a_cfg_wr_apply: assert property (
    wr_data_i && ptr == 8'h09 |=> ##[0:1] cfg_o == (wv & 8'he4)) else $error("cfg write");
  a_unmap_zero: assert property (ptr == 8'h05 |=> rdata_o == 8'h00) else $error("unmap");
  a_frac_low: assert property (ptr == 8'h10 |=> rdata_o[5:0] == 6'h00) else $error("frac");
  a_stby_hold: assert property (
    cfg_o[6] && $past(cfg_o[6]) && ptr == 8'h00 && $stable(ptr) |=> $stable(rdata_o))
    else $error("standby");
  a_run_follow: assert property (rstn_i |=> conv_run_o == !$past(cfg_o[6]))
    else $error("run");
  a_overtemp_output_primary_follow: assert property (
    1'b1 |=> overtemp_output_primary_oe_n_o == !$past(overtemp_output_primary_trip_i)) else $error("overtemp_output_primary");
  a_t2_nomask: assert property (
    cfg_o[5] && cfg_o[7] && $stable(cfg_o) && high_trip_i |=> !pin6_oe_n_o)
    else $error("overtemp_output_secondary");
  a_alert_mask: assert property (
    !cfg_o[5] && cfg_o[7] && $stable(cfg_o) |=> pin6_oe_n_o) else $error("mask");
endmodule
bind trc_regs trc_regs_chk u_chk (.mclk_i(mclk_i), .rstn_i(rstn_i), .wr_first_i(wr_first_i),
  .wr_data_i(wr_data_i), .wdata_i(wdata_i), .high_trip_i(high_trip_i),
  .overtemp_output_primary_trip_i(overtemp_output_primary_trip_i), .rdata_o(rdata_o), .cfg_o(cfg_o), .conv_run_o(conv_run_o),
  .overtemp_output_primary_oe_n_o(overtemp_output_primary_oe_n_o), .pin6_oe_n_o(pin6_oe_n_o));
`default_nettype wire

//--- trc_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// bench
module trc_regs_bench;
  logic mclk_i = 0, rstn_i = 0, conv_done_i = 0, conv_remote_i = 0, remote_short_i = 0;
  logic alert_req_i = 0, high_trip_i = 0, overtemp_output_primary_trip_i = 0;
  logic wr_first_i, wr_data_i, rd_i, overtemp_output_primary_oe_n_o, pin6_oe_n_o;
  logic conv_run_o, overtemp_output_primary_out_o, pin6_out_o;
  logic [7:0] wdata_i, rdata_o, cfg_o, hb = 0;
  logic [1:0] op = 0, conv_frac_i = 0;
  logic signed [9:0] conv_int_i = 0;
  int errors = 0, checks_done = 0;
  always #2.5 mclk_i = ~mclk_i;
  trc_host host (.mclk_i(mclk_i), .op_i(op), .byte_i(hb), .wr_first_o(wr_first_i),
    .wr_data_o(wr_data_i), .rd_o(rd_i), .wdata_o(wdata_i));
  trc_regs dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .wr_first_i(wr_first_i),
    .wr_data_i(wr_data_i), .rd_i(rd_i), .wdata_i(wdata_i), .conv_done_i(conv_done_i),
    .conv_remote_i(conv_remote_i), .conv_int_i(conv_int_i), .conv_frac_i(conv_frac_i),
    .remote_short_i(remote_short_i), .alert_req_i(alert_req_i), .high_trip_i(high_trip_i),
    .overtemp_output_primary_trip_i(overtemp_output_primary_trip_i), .rdata_o(rdata_o), .conv_run_o(conv_run_o), .cfg_o(cfg_o),
    .overtemp_output_primary_out_o(overtemp_output_primary_out_o), .overtemp_output_primary_oe_n_o(overtemp_output_primary_oe_n_o), .pin6_out_o(pin6_out_o),
    .pin6_oe_n_o(pin6_oe_n_o));
  task chk(input logic [7:0] s, input logic [7:0] e);
    #1;
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task acc(input logic [1:0] o, input logic [7:0] b);
    @(posedge mclk_i);
    op <= o;
    hb <= b;
    @(posedge mclk_i);
    op <= 2'd0;
    repeat (3) @(posedge mclk_i);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    acc(1, a);
    chk(rdata_o, e);
    acc(3, 0);
  endtask
  task w(input logic [7:0] a, input logic [7:0] d);
    acc(1, a);
    acc(2, d);
  endtask
  task cv(input logic r, input logic signed [9:0] t, input logic [1:0] f);
    @(posedge mclk_i);
    conv_done_i <= 1;
    conv_remote_i <= r;
    conv_int_i <= t;
    conv_frac_i <= f;
    @(posedge mclk_i);
    conv_done_i <= 0;
  endtask
  task wrap_up;
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #50000;
    errors++;
    wrap_up;
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    rstn_i <= 1;
    cv(0, 25, 0);
    repeat (2) @(posedge mclk_i);
    chk(rdata_o, 8'h19);
    chk(conv_run_o, 1);
    rd(8'h10, 0);
    rd(8'h01, 0);
    rd(8'h03, 0);
    cv(0, -5, 0);
    rd(0, 0);
    cv(0, 150, 0);
    rd(0, 8'h7f);
    cv(1, 50, 3);
    rd(8'h10, 8'hc0);
    cv(1, 75, 1);
    rd(8'h10, 8'h40);
    rd(8'h01, 8'h32);
    cv(1, 75, 1);
    rd(8'h01, 8'h4b);
    w(8'h09, 8'h04);
    rd(8'h03, 8'h04);
    rd(0, 8'h7f);
    cv(0, -55, 0);
    rd(0, 8'h09);
    cv(0, 250, 0);
    rd(0, 8'hff);
    cv(1, 10, 0);
    rd(8'h01, 8'h4a);
    w(8'h09, 8'hff);
    rd(8'h03, 8'he4);
    chk(cfg_o, 8'he4);
    cv(0, 0, 0);
    rd(0, 8'hff);
    chk(conv_run_o, 0);
    @(posedge mclk_i);
    high_trip_i <= 1;
    overtemp_output_primary_trip_i <= 1;
    alert_req_i <= 1;
    repeat (3) @(posedge mclk_i);
    chk(pin6_oe_n_o, 0);
    chk(overtemp_output_primary_oe_n_o, 0);
    chk(overtemp_output_primary_out_o, 0);
    chk(pin6_out_o, 0);
    w(8'h09, 8'hc0);
    chk(pin6_oe_n_o, 1);
    chk(conv_run_o, 0);
    w(8'h09, 8'h00);
    chk(pin6_oe_n_o, 0);
    chk(conv_run_o, 1);
    @(posedge mclk_i);
    remote_short_i <= 1;
    repeat (4) @(posedge mclk_i);
    cv(1, 100, 0);
    rd(8'h01, 8'h4a);
    w(8'h01, 8'h55);
    rd(8'h01, 8'h4a);
    rd(8'h05, 0);
    wrap_up;
  end
endmodule
`default_nettype wire
